/* File: sysconfig_pkg.sv */
// Constants of the system configuration register bank: map, reset values, field masks, encodings.
// Assumes a 32-bit byte-addressed register bus and one 100 MHz clock.
package sysconfig_pkg;

    // ----------------------------------------------------------------
    // Bank placement and bus answers
    // ----------------------------------------------------------------
    localparam logic [31:0] BANK_BASE = 32'h4004_8000;
    localparam int BANK_LOW_BITS = 14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [3:0] FULL_STROBE = 4'hF;

    // ----------------------------------------------------------------
    // Read-write registers: offset, value after reset, writable bits
    // ----------------------------------------------------------------
    localparam int NUM_RW = 24;
    localparam int IDX_REMAP = 0;
    localparam int IDX_PRESET = 1;
    localparam int IDX_PLL_SEL = 6;
    localparam int IDX_PLL_COMMIT = 7;
    localparam int IDX_MAIN_SEL = 8;
    localparam int IDX_MAIN_COMMIT = 9;
    localparam int IDX_BUS_DIV = 10;
    localparam int IDX_GATES = 11;
    localparam int IDX_SPI_DIV = 12;
    localparam int IDX_UART_DIV = 13;
    localparam int IDX_WDT_SEL = 14;
    localparam int IDX_WDT_COMMIT = 15;
    localparam int IDX_WDT_DIV = 16;
    localparam int IDX_EDGE = 19;
    localparam int IDX_ENABLE = 20;
    localparam int IDX_SLEEP = 21;
    localparam int IDX_WAKE = 22;
    localparam int IDX_RUN = 23;
    localparam logic [13:0] RW_OFFSET [NUM_RW] = '{
        14'h000, 14'h004, 14'h008, 14'h020, 14'h024, 14'h028, 14'h040, 14'h044,
        14'h070, 14'h074, 14'h078, 14'h080, 14'h094, 14'h098, 14'h0D0, 14'h0D4,
        14'h0D8, 14'h150, 14'h154, 14'h200, 14'h204, 14'h230, 14'h234, 14'h238};
    localparam logic [31:0] RW_RESET [NUM_RW] = '{
        32'h002, 32'h000, 32'h000, 32'h000, 32'h000, 32'h080, 32'h000, 32'h000,
        32'h000, 32'h000, 32'h001, 32'h85F, 32'h000, 32'h000, 32'h000, 32'h000,
        32'h000, 32'h000, 32'h004, 32'h000, 32'h000, 32'h0000_0000, 32'h0000_EDF0, 32'h0000_EDF0};
    localparam logic [31:0] WAKE_FIELD = 32'h0000_1F01;
    localparam logic [31:0] RW_MASK [NUM_RW] = '{
        32'h003, 32'h001, 32'h07F, 32'h003, 32'h1FF, 32'h0FF, 32'h003, 32'h001,
        32'h003, 32'h001, 32'h0FF, 32'hFFFF, 32'h0FF, 32'h0FF, 32'h003, 32'h001,
        32'h0FF, 32'h01F, 32'h03FF_FFFF, WAKE_FIELD, WAKE_FIELD, 32'hFFFF, 32'hFFFF, 32'hFFFF};

    // ----------------------------------------------------------------
    // Read-only and write-only registers
    // ----------------------------------------------------------------
    localparam logic [13:0] OFF_PLL_LOCK = 14'h00C;
    localparam logic [13:0] OFF_RESET_CAUSE = 14'h030;
    localparam logic [13:0] OFF_POR_CAPTURE = 14'h100;
    localparam logic [13:0] OFF_WAKE_CLEAR = 14'h208;
    localparam logic [13:0] OFF_WAKE_STATUS = 14'h20C;
    localparam logic [13:0] OFF_PART_ID = 14'h3F4;

    // ----------------------------------------------------------------
    // Clock channels and source encodings
    // ----------------------------------------------------------------
    localparam int NUM_SEL = 3;
    localparam int ACT_PLL = 0;
    localparam int ACT_MAIN = 1;
    localparam int ACT_WDT = 2;
    localparam int SEL_IDX [NUM_SEL] = '{IDX_PLL_SEL, IDX_MAIN_SEL, IDX_WDT_SEL};
    localparam int COMMIT_IDX [NUM_SEL] = '{IDX_PLL_COMMIT, IDX_MAIN_COMMIT, IDX_WDT_COMMIT};
    localparam logic [1:0] PLL_SRC_CRYSTAL = 2'h1;
    localparam logic [1:0] MAIN_SRC_RC = 2'h0;
    localparam logic [1:0] MAIN_SRC_PLL_IN = 2'h1;
    localparam logic [1:0] MAIN_SRC_LOWPOWER = 2'h2;
    localparam logic [1:0] MAIN_SRC_PLL_OUT = 2'h3;
    localparam logic [1:0] WDT_SRC_MAIN = 2'h1;
    localparam logic [1:0] WDT_SRC_LOWPOWER = 2'h2;
    localparam int OSC_CRYSTAL = 0;
    localparam int OSC_RC = 1;
    localparam int OSC_LOWPOWER = 2;
    localparam logic [2:0] OSC_RESET = 3'h2;

    // Dividers: 0 bus, 1 serial periph, 2 async serial, 3 watchdog
    localparam int NUM_DIV = 4;
    localparam int DIV_IDX [NUM_DIV] = '{IDX_BUS_DIV, IDX_SPI_DIV, IDX_UART_DIV, IDX_WDT_DIV};

    // Wake-up pins and their status bit positions
    localparam int NUM_WAKE = 6;
    localparam int WAKE_BIT [NUM_WAKE] = '{0, 8, 9, 10, 11, 12};
    localparam int CAUSE_BITS = 5;
endpackage

/* File: system_config_clock_register_bank.sv */
// System configuration bank: clock source selection with commit, dividers, gating, wake-up start logic.
// Assumes an AXI4-Lite master on clock_i and pins from outside the clock domain.
// How it works
// - Tracks which of crystal, RC and low-power oscillators the main and watchdog clocks use, as one mask.
// - Main clock runs from the internal RC oscillator until software commits another.
// - Bus clock gate register at 0x080 resets to 0x85F and drives gates.
// - Serial, async serial and watchdog dividers at 0x094/0x098/0x0D8 make clock ticks.
// - Registers are aligned 32-bit words; partial or misaligned accesses are refused.
// - Bank decodes relative to base 0x4004_8000.
// - Five port-0 pins and one port-1 pin feed the wake-up start logic.
// - PLL source select 0x040 applies when commit 0x044 goes from 0 to 1.
// - Main source select 0x070 applies when commit 0x074 goes from 0 to 1.
// - Watchdog source select 0x0D0 applies when commit 0x0D4 goes from 0 to 1.
// - Bus clock divider at 0x078 resets to 1.
// - Reset cause status at 0x030 is read-only, zero after reset, sticky.
// - Edge select at 0x200 picks rising or falling edge per wake-up pin.
// - Enable at 0x204 lets each wake-up pin latch an event.
// - Write-only clear at 0x208 clears latched wake-up events.
// - Status at 0x20C reports latched wake-up events.
// - Deep-sleep power-down config at 0x230 resets to zero.
// - Wake and run power-down configs at 0x234/0x238 reset to 0xEDF0.
// - Pin levels are captured once after reset into read-only 0x100.
// - Tick calibration 0x154 resets to 4; brown-out control 0x150 resets to 0.
// - Remap field picks vector source: 0 boot ROM, 1 SRAM, 2/3 flash.
// - Serial periph reset bit holds reset at 0, releases at 1, resets 0.
`timescale 1ns/100ps

module system_config_clock_register_bank #(
    parameter logic [31:0] PART_ID = 32'h0000_5A5A // Arbitrary identifier value
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [31:0] awaddr_i,
    input wire logic [2:0] awprot_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [31:0] araddr_i,
    input wire logic [2:0] arprot_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic pll_locked_i,
    input wire logic [sysconfig_pkg::CAUSE_BITS-1:0] reset_event_i,
    input wire logic [31:0] por_pins_i,
    input wire logic [sysconfig_pkg::NUM_WAKE-1:0] wake_pins_i,
    output logic [1:0] pll_source_o,
    output logic [1:0] main_source_o,
    output logic [1:0] watchdog_source_o,
    output logic [2:0] osc_in_use_o,
    output logic [31:0] bus_clock_gates_o,
    output logic [sysconfig_pkg::NUM_DIV-1:0] periph_tick_o,
    output logic spi_reset_release_o,
    output logic [1:0] vector_remap_o,
    output logic [31:0] powerdown_run_o,
    output logic [31:0] powerdown_sleep_o,
    output logic [31:0] powerdown_wake_o,
    output logic wakeup_o
);
    import sysconfig_pkg::*;

    typedef struct packed {
        logic [NUM_RW-1:0][31:0] rw;
        logic [NUM_SEL-1:0][1:0] act;
        logic [2:0] osc_use;
        logic [CAUSE_BITS-1:0] cause;
        logic [31:0] por_cap;
        logic por_done;
        logic [2:0] lock_sync;
        logic lock;
        logic [NUM_WAKE-1:0][2:0] wake_sync;
        logic [NUM_WAKE-1:0] wake_lvl;
        logic [12:0] wake_stat;
        logic [NUM_DIV-1:0][7:0] div_cnt;
        logic [NUM_DIV-1:0] tick;
        logic aw_held;
        logic w_held;
        logic [31:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_type;

    state_type st;
    state_type nxt;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic have_aw;
    logic have_w;
    logic do_write;
    logic wr_in_bank;
    logic wr_ok;
    logic rd_in_bank;
    logic [12:0] clear_bits;
    logic [12:0] wake_set;
    logic [NUM_WAKE-1:0] wake_settled;
    logic [NUM_WAKE-1:0] wake_hit;
    logic [NUM_DIV-1:0] div_wrap;
    logic [NUM_DIV-1:0][7:0] div_cnt_new;
    logic [NUM_SEL-1:0] commit_rise;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic state_type reset_state();
        state_type s;
        s = '0;
        for (int k = 0; k < NUM_RW; k++) begin
            s.rw[k] = RW_RESET[k];
        end
        s.osc_use = OSC_RESET;
        return s;
    endfunction

    // Which oscillators the committed selections keep busy
    function automatic logic [2:0] osc_mask(input logic [NUM_SEL-1:0][1:0] a);
        logic [2:0] m;
        logic [2:0] pll_osc;
        logic [2:0] main_osc;
        m = '0;
        pll_osc = '0;
        main_osc = '0;
        if (a[ACT_PLL] == PLL_SRC_CRYSTAL) begin
            pll_osc[OSC_CRYSTAL] = 1'b1;
        end else begin
            pll_osc[OSC_RC] = 1'b1;
        end
        case (a[ACT_MAIN])
            MAIN_SRC_PLL_IN, MAIN_SRC_PLL_OUT: main_osc = pll_osc;
            MAIN_SRC_LOWPOWER: main_osc[OSC_LOWPOWER] = 1'b1;
            default: main_osc[OSC_RC] = 1'b1;
        endcase
        case (a[ACT_WDT])
            WDT_SRC_MAIN: m = main_osc;
            WDT_SRC_LOWPOWER: m[OSC_LOWPOWER] = 1'b1;
            default: m[OSC_RC] = 1'b1;
        endcase
        return m | main_osc;
    endfunction

    function automatic logic [31:0] read_word(input state_type s, input logic [13:0] off, input logic [31:0] id);
        logic [31:0] w;
        w = '0;
        for (int k = 0; k < NUM_RW; k++) begin
            if (off == RW_OFFSET[k]) begin
                w = s.rw[k];
            end
        end
        if (off == OFF_PLL_LOCK) begin
            w = {31'h0, s.lock};
        end
        if (off == OFF_RESET_CAUSE) begin
            w = {{(32 - CAUSE_BITS){1'b0}}, s.cause};
        end
        if (off == OFF_POR_CAPTURE) begin
            w = s.por_cap;
        end
        if (off == OFF_WAKE_STATUS) begin
            w = {19'h0, s.wake_stat};
        end
        if (off == OFF_PART_ID) begin
            w = id;
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Wake-up pins: three-stage synchroniser, edge detect
    // ----------------------------------------------------------------
    // A change counts only once stages two and three agree.
    for (genvar g = 0; g < NUM_WAKE; g++) begin : g_wake
        assign wake_settled[g] = st.wake_sync[g][1] == st.wake_sync[g][2];
        assign wake_hit[g] = wake_settled[g] && (st.wake_sync[g][2] != st.wake_lvl[g])
            && st.rw[IDX_ENABLE][WAKE_BIT[g]]
            && (st.rw[IDX_EDGE][WAKE_BIT[g]] == st.wake_sync[g][2]);
    end

    // ----------------------------------------------------------------
    // Peripheral dividers
    // ----------------------------------------------------------------
    // Divide value 0 stops the tick; N gives one tick every N cycles.
    for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
        assign div_wrap[g] = (st.rw[DIV_IDX[g]][7:0] != 8'h00)
            && (st.div_cnt[g] >= st.rw[DIV_IDX[g]][7:0] - 8'h01);
        assign div_cnt_new[g] = (div_wrap[g] || st.rw[DIV_IDX[g]][7:0] == 8'h00) ? 8'h00 : st.div_cnt[g] + 8'h01;
    end

    // ----------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------
    assign awready_o = !st.aw_held && !st.bvalid;
    assign wready_o = !st.w_held && !st.bvalid;
    assign arready_o = !st.rvalid;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt = st;
        wr_addr = st.aw_held ? st.aw_addr : awaddr_i;
        wr_data = st.w_held ? st.w_data : wdata_i;
        wr_strb = st.w_held ? st.w_strb : wstrb_i;
        have_aw = st.aw_held | (awvalid_i & awready_o);
        have_w = st.w_held | (wvalid_i & wready_o);
        do_write = have_aw & have_w & !st.bvalid;
        wr_in_bank = wr_addr[31:BANK_LOW_BITS] == BANK_BASE[31:BANK_LOW_BITS];
        wr_ok = wr_in_bank && (wr_addr[1:0] == 2'b00) && (wr_strb == FULL_STROBE);
        rd_in_bank = araddr_i[31:BANK_LOW_BITS] == BANK_BASE[31:BANK_LOW_BITS];
        clear_bits = '0;
        wake_set = '0;
        commit_rise = '0;

        if (awvalid_i && awready_o) begin
            nxt.aw_addr = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            nxt.w_data = wdata_i;
            nxt.w_strb = wstrb_i;
        end
        nxt.aw_held = have_aw & !do_write;
        nxt.w_held = have_w & !do_write;
        if (st.bvalid && bready_i) begin
            nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            nxt.bvalid = 1'b1;
            nxt.bresp = !wr_in_bank ? RESP_DECERR : (wr_ok ? RESP_OKAY : RESP_SLVERR);
            if (wr_ok) begin
                for (int k = 0; k < NUM_RW; k++) begin
                    if (wr_addr[13:0] == RW_OFFSET[k]) begin
                        nxt.rw[k] = wr_data & RW_MASK[k];
                    end
                end
                if (wr_addr[13:0] == OFF_WAKE_CLEAR) begin
                    clear_bits = wr_data[12:0] & WAKE_FIELD[12:0];
                end
            end
        end

        // Selection only takes effect on a 0 to 1 step of its commit bit
        for (int c = 0; c < NUM_SEL; c++) begin
            commit_rise[c] = !st.rw[COMMIT_IDX[c]][0] && nxt.rw[COMMIT_IDX[c]][0];
            if (commit_rise[c]) begin
                nxt.act[c] = nxt.rw[SEL_IDX[c]][1:0];
            end
        end
        nxt.osc_use = osc_mask(nxt.act);

        if (st.rvalid && rready_i) begin
            nxt.rvalid = 1'b0;
        end
        if (arvalid_i && arready_o) begin
            nxt.rvalid = 1'b1;
            if (!rd_in_bank) begin
                nxt.rresp = RESP_DECERR;
                nxt.rdata = '0;
            end else if (araddr_i[1:0] != 2'b00) begin
                nxt.rresp = RESP_SLVERR;
                nxt.rdata = '0;
            end else begin
                nxt.rresp = RESP_OKAY;
                nxt.rdata = read_word(st, araddr_i[13:0], PART_ID);
            end
        end

        nxt.lock_sync = {st.lock_sync[1:0], pll_locked_i};
        if (st.lock_sync[1] == st.lock_sync[2]) begin
            nxt.lock = st.lock_sync[2];
        end
        for (int g = 0; g < NUM_WAKE; g++) begin
            nxt.wake_sync[g] = {st.wake_sync[g][1:0], wake_pins_i[g]};
            if (wake_settled[g]) begin
                nxt.wake_lvl[g] = st.wake_sync[g][2];
            end
            wake_set[WAKE_BIT[g]] = wake_hit[g];
        end
        // An event in the clearing cycle survives the clear
        nxt.wake_stat = (st.wake_stat & ~clear_bits) | wake_set;

        nxt.cause = st.cause | reset_event_i;
        if (!st.por_done) begin
            nxt.por_cap = por_pins_i;
            nxt.por_done = 1'b1;
        end
        nxt.div_cnt = div_cnt_new;
        nxt.tick = div_wrap;

        if (reset_i) begin
            nxt = reset_state();
        end
    end

    always_ff @(posedge clock_i) begin
        st <= nxt;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign bresp_o = st.bresp;
    assign bvalid_o = st.bvalid;
    assign rdata_o = st.rdata;
    assign rresp_o = st.rresp;
    assign rvalid_o = st.rvalid;
    assign pll_source_o = st.act[ACT_PLL];
    assign main_source_o = st.act[ACT_MAIN];
    assign watchdog_source_o = st.act[ACT_WDT];
    assign osc_in_use_o = st.osc_use;
    assign bus_clock_gates_o = st.rw[IDX_GATES];
    assign periph_tick_o = st.tick;
    assign spi_reset_release_o = st.rw[IDX_PRESET][0];
    assign vector_remap_o = st.rw[IDX_REMAP][1:0];
    assign powerdown_run_o = st.rw[IDX_RUN];
    assign powerdown_sleep_o = st.rw[IDX_SLEEP];
    assign powerdown_wake_o = st.rw[IDX_WAKE];
    assign wakeup_o = |st.wake_stat;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence rd_reserved_s;
        arvalid_i && arready_o && rd_in_bank && araddr_i[13:0] == 14'h010;
    endsequence

    sequence spi_tick_pair_s;
        (periph_tick_o[1] && st.rw[IDX_SPI_DIV][7:0] == 8'h02) ##1 $stable(st.rw[IDX_SPI_DIV]);
    endsequence

    reset_defaults_a: assert property (@(posedge clock_i)
        reset_i |=> bus_clock_gates_o == 32'h85F && vector_remap_o == 2'h2 && !spi_reset_release_o
            && powerdown_run_o == 32'hEDF0 && powerdown_sleep_o == 32'h0)
        else $error("reset values wrong");

    main_rc_reset_a: assert property (@(posedge clock_i)
        reset_i |=> main_source_o == MAIN_SRC_RC && osc_in_use_o[OSC_RC] && !osc_in_use_o[OSC_CRYSTAL])
        else $error("main clock not on RC after reset");

    main_commit_a: assert property (@(posedge clock_i) disable iff (reset_i)
        $changed(main_source_o) |-> $past(commit_rise[ACT_MAIN]))
        else $error("main source changed without commit");

    pll_commit_a: assert property (@(posedge clock_i) disable iff (reset_i)
        commit_rise[ACT_PLL] |=> pll_source_o == $past(nxt.rw[IDX_PLL_SEL][1:0]))
        else $error("PLL source not applied on commit");

    spi_period_a: assert property (@(posedge clock_i) disable iff (reset_i)
        spi_tick_pair_s |-> !periph_tick_o[1] ##1 periph_tick_o[1])
        else $error("serial divider period wrong");

    wake_latch_a: assert property (@(posedge clock_i) disable iff (reset_i)
        wake_hit[0] |=> st.wake_stat[0] && wakeup_o)
        else $error("wake event not latched");

    wake_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (clear_bits[0] && !wake_hit[0]) |=> !st.wake_stat[0])
        else $error("wake clear ignored");

    strobe_refuse_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (do_write && wr_in_bank && wr_strb != FULL_STROBE) |=> bvalid_o && bresp_o == RESP_SLVERR
            && $stable(st.rw))
        else $error("partial write not refused");

    reserved_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
        rd_reserved_s |=> rvalid_o && rdata_o == 32'h0 && rresp_o == RESP_OKAY)
        else $error("reserved read not zero");

    outside_bank_a: assert property (@(posedge clock_i) disable iff (reset_i)
        (arvalid_i && arready_o && !rd_in_bank) |=> rresp_o == RESP_DECERR)
        else $error("outside bank not decode error");

    cause_sticky_a: assert property (@(posedge clock_i) disable iff (reset_i)
        reset_event_i[0] |=> st.cause[0] [*3])
        else $error("reset cause lost");
endmodule

/* File: axi_lite_master_model.sv */
// AXI4-Lite master standing in for the processor core on the register bus.
// Assumes a slave clocked by clock_i; the bench calls write and read one at a time.
`timescale 1ns/100ps
module axi_lite_master_model (
    input wire logic clock_i,
    output logic [31:0] awaddr_o, output logic awvalid_o, input wire logic awready_i,
    output logic [31:0] wdata_o, output logic [3:0] wstrb_o, output logic wvalid_o, input wire logic wready_i,
    input wire logic [1:0] bresp_i, input wire logic bvalid_i, output logic bready_o,
    output logic [31:0] araddr_o, output logic arvalid_o, input wire logic arready_i,
    input wire logic [31:0] rdata_i, input wire logic [1:0] rresp_i, input wire logic rvalid_i, output logic rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
    end

    // Released payload is inverted so a slave never sees a stale value
    task automatic write(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
        @(posedge clock_i);
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= s;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        while (1'b1) begin
            @(posedge clock_i);
            if (awready_i && awvalid_o) begin
                awvalid_o <= 1'b0;
                awaddr_o <= ~a;
            end
            if (wready_i && wvalid_o) begin
                wvalid_o <= 1'b0;
                wdata_o <= ~d;
            end
            if (bvalid_i) begin
                r = bresp_i;
                bready_o <= 1'b0;
                break;
            end
        end
    endtask

    task automatic read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        while (1'b1) begin
            @(posedge clock_i);
            if (arready_i && arvalid_o) begin
                arvalid_o <= 1'b0;
                araddr_o <= ~a;
            end
            if (rvalid_i) begin
                d = rdata_i;
                r = rresp_i;
                rready_o <= 1'b0;
                break;
            end
        end
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench: register map, clock source commit, dividers, wake-up start logic.
// Assumes the bank package and the AXI4-Lite master model are compiled first.
`timescale 1ns/100ps
module testbench;
    import sysconfig_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, wakeup, spi_release;
    logic [31:0] awaddr, wdata, araddr, rdata, gates, pd_run, pd_sleep, pd_wake;
    logic [31:0] por_pins = 32'h0000_0A5C;
    logic [3:0] wstrb, ticks;
    logic [1:0] bresp, rresp, pll_src, main_src, wdt_src, remap;
    logic [2:0] osc_use;
    logic [5:0] wake_pins = 6'h00;
    logic [4:0] reset_event = 5'h00;
    logic pll_lock = 1'b0;
    int n_uart;
    int n_errors = 0;
    int samples_checked = 0;
    int n_bus, n_spi;
    always #5 clock = ~clock;

    axi_lite_master_model axi_lite_master_model_inst (.clock_i(clock), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
        .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
        .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
    system_config_clock_register_bank system_config_clock_register_bank_inst (.clock_i(clock), .reset_i(reset),
        .awaddr_i(awaddr), .awprot_i(3'h0), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
        .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
        .araddr_i(araddr), .arprot_i(3'h0), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
        .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .pll_locked_i(pll_lock), .reset_event_i(reset_event),
        .por_pins_i(por_pins), .wake_pins_i(wake_pins), .pll_source_o(pll_src), .main_source_o(main_src),
        .watchdog_source_o(wdt_src), .osc_in_use_o(osc_use), .bus_clock_gates_o(gates), .periph_tick_o(ticks),
        .spi_reset_release_o(spi_release), .vector_remap_o(remap), .powerdown_run_o(pd_run),
        .powerdown_sleep_o(pd_sleep), .powerdown_wake_o(pd_wake), .wakeup_o(wakeup));

    task automatic chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] off, d, input logic [3:0] s = FULL_STROBE, input logic [1:0] er = RESP_OKAY);
        logic [1:0] r;
        axi_lite_master_model_inst.write(BANK_BASE + off, d, s, r);
        chk("write response", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [31:0] off, exp, input logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        axi_lite_master_model_inst.read(BANK_BASE + off, d, r);
        chk("read data", exp, d);
        chk("read response", {30'h0, er}, {30'h0, r});
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < NUM_RW; i++) begin
            rd({18'h0, RW_OFFSET[i]}, RW_RESET[i]);
        end
        chk("main source", 32'h0, {30'h0, main_src});
        chk("oscillators", {29'h0, OSC_RESET}, {29'h0, osc_use});
        rd(32'h100, 32'h0000_0A5C);
        chk("powerdown run", 32'h0000_EDF0, pd_run);
        chk("powerdown wake", 32'h0000_EDF0, pd_wake);
        chk("powerdown sleep", 32'h0, pd_sleep);
        $display("test reset values done");
        wr(32'h010, 32'hFFFF_FFFF);
        rd(32'h010, 32'h0);
        wr(32'h030, 32'h1F);
        rd(32'h030, 32'h0);
        reset_event <= 5'h01;
        @(posedge clock);
        reset_event <= 5'h00;
        rd(32'h030, 32'h1);
        pll_lock <= 1'b1;
        repeat (5) @(posedge clock);
        rd(32'h00C, 32'h1);
        wr(32'h154, 32'h0, 4'h3, RESP_SLVERR);
        rd(32'h156, 32'h0, RESP_SLVERR);
        rd(32'h154, 32'h004);
        wr(32'h4000, 32'h0, FULL_STROBE, RESP_DECERR);
        rd(32'h4000, 32'h0, RESP_DECERR);
        $display("test refusals done");
        wr(32'h040, 32'h1);
        wr(32'h070, 32'h3);
        wr(32'h0D0, 32'h2);
        repeat (2) @(posedge clock);
        chk("sources before commit", 32'h0, {26'h0, pll_src, main_src, wdt_src});
        for (int i = 0; i < NUM_SEL; i++) begin
            wr({18'h0, RW_OFFSET[COMMIT_IDX[i]]}, 32'h0);
            wr({18'h0, RW_OFFSET[COMMIT_IDX[i]]}, 32'h1);
        end
        repeat (2) @(posedge clock);
        chk("sources", {26'h0, PLL_SRC_CRYSTAL, MAIN_SRC_PLL_OUT, WDT_SRC_LOWPOWER}, {26'h0, pll_src, main_src, wdt_src});
        chk("oscillators committed", 32'h5, {29'h0, osc_use});
        wr(32'h000, 32'h1);
        wr(32'h004, 32'h1);
        wr(32'h080, 32'h1234);
        wr(32'h094, 32'h2);
        wr(32'h098, 32'h5);
        repeat (2) @(posedge clock);
        chk("remap and spi reset", 32'h3, {29'h0, remap, spi_release});
        chk("gates", 32'h1234, gates);
        n_bus = 0;
        n_spi = 0;
        n_uart = 0;
        repeat (30) begin
            @(posedge clock);
            n_bus += (ticks[0] === 1'b1);
            n_spi += (ticks[1] === 1'b1);
            n_uart += (ticks[2] === 1'b1) + (ticks[3] !== 1'b0);
        end
        chk("bus ticks", 32'h1E, n_bus);
        chk("spi ticks", 32'h0F, n_spi);
        chk("uart ticks", 32'h06, n_uart);
        $display("test clocks done");
        wr(32'h200, 32'h1001);
        wr(32'h204, 32'h1101);
        wake_pins <= 6'h27;
        repeat (10) @(posedge clock);
        rd(32'h20C, 32'h1001);
        chk("wakeup", 32'h1, {31'h0, wakeup});
        wr(32'h208, 32'h1001);
        rd(32'h20C, 32'h0);
        $display("test wake-up done");
        complete_run();
    end

    initial begin
        repeat (3000) @(posedge clock);
        n_errors++;
        complete_run();
    end
endmodule
